// file: core/mpf_regs.svh
`ifndef MPF_REGS_SVH
`define MPF_REGS_SVH

`define MPF_PIX_W 12
`define MPF_Y_HI 11
`define MPF_Y_LO 4
`define MPF_LOW_HI 7
`define MPF_HIGH_LO 8
`define MPF_NIB_W 4
`define MPF_ZERO_NIB 4'h0
`define MPF_ZERO_BYTE 8'h00
`define MPF_ZERO_PIX 12'h000
`define MPF_MAX_BYTES 4
`define MPF_CNT_W 3
`define MPF_CNT_NONE 3'h0
`define MPF_CNT_ONE 3'h1
`define MPF_N_MONO8 3'h1
`define MPF_N_MONO16 3'h2
`define MPF_N_PACK 3'h3
`define MPF_N_YUV 3'h4
`define MPF_MAX16 16'h0fff
`define MPF_CODE_W 32

`endif

// file: core/mpf_pkg.sv
package mpf_pkg;
  `include "mpf_regs.svh"

  // layout choice, taken once per frame
  typedef enum logic [2:0] {
    MPF_GRAY_8BIT,
    MPF_GRAY_16BIT,
    MPF_GRAY_12BIT_PACKED,
    MPF_YUV422_A,
    MPF_YUV422_YUYV
  } mpf_fmt_t;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [`MPF_PIX_W-1:0] data;
  } mpf_pix_t;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } mpf_byte_t;
endpackage

// file: core/mpf_packer.sv
`timescale 1ns/1ps
// Contract
// - One format setting picks the byte layout for every pixel of a frame.
// - Gray 8-bit sends one byte per pixel in transmission order.
// - Gray 8-bit bytes are unsigned, 0x00 is level zero, 0xff is 255.
// - Gray 16-bit sends a 16-bit word per pixel with 12 bits of brightness.
// - Gray 16-bit keeps the 12 bits from bit zero, upper four bits zero.
// - Gray 16-bit sends low byte then high byte, pixels in order.
// - Gray 16-bit words never exceed 0x0fff.
// - Gray 16-bit frames report the 12-bit gray code in the leader.
// - Packed 12-bit puts each pixel pair into exactly three bytes.
// - Packed bytes are even 11..4, odd 3..0 with even 3..0, odd 11..4.
// - Packed 12-bit values are unsigned from 0x000 to 0xfff.
// - Both 4:2:2 modes send the pixel's 8-bit gray value as luma.
// - Both 4:2:2 modes send every chroma sample as zero.
// - Both 4:2:2 modes send two luma, one U and one V per pair; a lone last pixel takes a zero luma partner.
// - Mode yuv422_a orders bytes as the colour packed 4:2:2 output.
// - Mode yuv422_yuyv orders bytes as the colour YUYV 4:2:2 output.
`include "mpf_regs.svh"

module mpf_packer
  import mpf_pkg::*;
#(
  parameter logic [`MPF_CODE_W-1:0] CODE_GRAY8 = 32'h0000_0001,
  parameter logic [`MPF_CODE_W-1:0] CODE_GRAY12 = 32'h0000_0002,
  parameter logic [`MPF_CODE_W-1:0] CODE_PACK12 = 32'h0000_0003,
  parameter logic [`MPF_CODE_W-1:0] CODE_YUV_A = 32'h0000_0004,
  parameter logic [`MPF_CODE_W-1:0] CODE_YUYV = 32'h0000_0005
) (
  input wire logic clk,
  input wire logic resetn,
  input wire mpf_fmt_t fmt_sel,
  input wire mpf_pix_t pix_in,
  input wire logic pix_valid,
  output logic pix_ready,
  output mpf_byte_t byte_out,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [`MPF_CODE_W-1:0] leader_code
);

  function automatic logic [7:0] luma(input logic [`MPF_PIX_W-1:0] p);
    luma = p[`MPF_Y_HI:`MPF_Y_LO];
  endfunction

  mpf_fmt_t fmt_q;
  logic odd_q;
  logic [`MPF_PIX_W-1:0] even_q;
  logic even_sof_q;
  logic [7:0] bytes_q [0:`MPF_MAX_BYTES-1];
  logic [7:0] bytes_d [0:`MPF_MAX_BYTES-1];
  logic [`MPF_CNT_W-1:0] cnt_q;
  logic [`MPF_CNT_W-1:0] cnt_d;
  logic sof_q;
  logic eof_q;
  logic [`MPF_CODE_W-1:0] code_q;
  logic [`MPF_CODE_W-1:0] code_d;

  wire pix_take = pix_valid && pix_ready;
  wire byte_take = byte_valid && byte_ready;
  // a new frame picks up the setting on its first pixel
  wire mpf_fmt_t cur_fmt = pix_in.sof ? fmt_sel : fmt_q;
  wire paired = (cur_fmt == MPF_GRAY_12BIT_PACKED) ||
                (cur_fmt == MPF_YUV422_A) ||
                (cur_fmt == MPF_YUV422_YUYV);
  wire is_odd = pix_in.sof ? 1'b0 : odd_q;
  // an even pixel is parked until its partner arrives, unless it ends
  // the frame, in which case the pair closes with a zero partner
  wire hold_even = pix_take && paired && !is_odd && !pix_in.eof;
  wire load = pix_take && !hold_even;
  wire [`MPF_PIX_W-1:0] ev = is_odd ? even_q : pix_in.data;
  wire [`MPF_PIX_W-1:0] od = is_odd ? pix_in.data : `MPF_ZERO_PIX;
  wire grp_sof = pix_in.sof || (is_odd && even_sof_q);

  // no output buffer beyond one group: new pixels wait until it drains
  assign pix_ready = (cnt_q == `MPF_CNT_NONE);
  assign byte_valid = (cnt_q != `MPF_CNT_NONE);
  // one driver for the whole carrier; eof marks only the group's last byte
  assign byte_out = '{sof: sof_q,
                      eof: eof_q && (cnt_q == `MPF_CNT_ONE),
                      data: bytes_q[0]};
  assign leader_code = code_q;

  always_comb begin
    for (int i = 0; i < `MPF_MAX_BYTES; i++) begin
      bytes_d[i] = bytes_q[i];
    end
    cnt_d = cnt_q;
    if (byte_take) begin
      for (int i = 0; i < `MPF_MAX_BYTES - 1; i++) begin
        bytes_d[i] = bytes_q[i+1];
      end
      bytes_d[`MPF_MAX_BYTES-1] = `MPF_ZERO_BYTE;
      cnt_d = cnt_q - `MPF_CNT_ONE;
    end
    if (load) begin
      case (cur_fmt)
        MPF_GRAY_8BIT: begin
          bytes_d[0] = luma(pix_in.data);
          cnt_d = `MPF_N_MONO8;
        end
        MPF_GRAY_16BIT: begin
          // little endian, upper nibble forced to zero
          bytes_d[0] = pix_in.data[`MPF_LOW_HI:0];
          bytes_d[1] = {`MPF_ZERO_NIB,
                        pix_in.data[`MPF_Y_HI:`MPF_HIGH_LO]};
          cnt_d = `MPF_N_MONO16;
        end
        MPF_GRAY_12BIT_PACKED: begin
          bytes_d[0] = luma(ev);
          bytes_d[1] = {od[`MPF_NIB_W-1:0], ev[`MPF_NIB_W-1:0]};
          bytes_d[2] = luma(od);
          cnt_d = `MPF_N_PACK;
        end
        MPF_YUV422_A: begin
          bytes_d[0] = `MPF_ZERO_BYTE;
          bytes_d[1] = luma(ev);
          bytes_d[2] = `MPF_ZERO_BYTE;
          bytes_d[3] = luma(od);
          cnt_d = `MPF_N_YUV;
        end
        default: begin
          bytes_d[0] = luma(ev);
          bytes_d[1] = `MPF_ZERO_BYTE;
          bytes_d[2] = luma(od);
          bytes_d[3] = `MPF_ZERO_BYTE;
          cnt_d = `MPF_N_YUV;
        end
      endcase
    end
  end

  // 16-bit gray carries 12 effective bits, so it reports as 12-bit gray
  always_comb begin
    code_d = code_q;
    if (pix_take && pix_in.sof) begin
      case (fmt_sel)
        MPF_GRAY_8BIT: code_d = CODE_GRAY8;
        MPF_GRAY_16BIT: code_d = CODE_GRAY12;
        MPF_GRAY_12BIT_PACKED: code_d = CODE_PACK12;
        MPF_YUV422_A: code_d = CODE_YUV_A;
        default: code_d = CODE_YUYV;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fmt_q <= MPF_GRAY_8BIT;
      odd_q <= 1'b0;
      even_q <= `MPF_ZERO_PIX;
      even_sof_q <= 1'b0;
      cnt_q <= `MPF_CNT_NONE;
      sof_q <= 1'b0;
      eof_q <= 1'b0;
      code_q <= CODE_GRAY8;
    end else begin
      // only a taken pixel commits the layout; a first pixel that is
      // offered but not yet taken leaves the setting alone
      if (pix_take) begin
        fmt_q <= cur_fmt;
      end
      cnt_q <= cnt_d;
      code_q <= code_d;
      if (hold_even) begin
        even_q <= pix_in.data;
        even_sof_q <= pix_in.sof;
      end
      if (pix_take) begin
        odd_q <= paired && !is_odd;
      end
      if (load) begin
        sof_q <= grp_sof;
        eof_q <= pix_in.eof;
      end else if (byte_take) begin
        sof_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `MPF_MAX_BYTES; i++) begin
        bytes_q[i] <= `MPF_ZERO_BYTE;
      end
    end else begin
      for (int i = 0; i < `MPF_MAX_BYTES; i++) begin
        bytes_q[i] <= bytes_d[i];
      end
    end
  end

  a_fmt_frame_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(pix_take && pix_in.sof) |=> fmt_q == $past(fmt_q))
    else $error("format changed inside a frame");

  a_leader_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(pix_take && pix_in.sof) |=> $stable(leader_code))
    else $error("leader code changed inside a frame");

  a_gray8_byte: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_8BIT) |=>
      byte_valid && cnt_q == `MPF_N_MONO8 &&
      byte_out.data == $past(pix_in.data[11:4]))
    else $error("gray 8-bit byte wrong");

  a_byte_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (byte_valid && !byte_ready) |=> byte_valid && $stable(byte_out))
    else $error("byte changed before it was taken");

  a_sof_once: assert property (
    @(posedge clk) disable iff (!resetn)
    (byte_take && byte_out.sof) |=> !byte_out.sof)
    else $error("frame start flag on more than one byte");

  a_gray16_count: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_16BIT) |=> cnt_q == `MPF_N_MONO16)
    else $error("gray 16-bit pixel not two bytes");

  a_gray16_order: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_16BIT) |=>
      byte_out.data == $past(pix_in.data[7:0]) &&
      bytes_q[1] == {`MPF_ZERO_NIB, $past(pix_in.data[11:8])})
    else $error("gray 16-bit byte order wrong");

  a_gray16_range: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_16BIT) |=>
      {bytes_q[1], bytes_q[0]} <= `MPF_MAX16)
    else $error("gray 16-bit word above range");

  a_leader_gray12: assert property (
    @(posedge clk) disable iff (!resetn)
    (pix_take && pix_in.sof && fmt_sel == MPF_GRAY_16BIT) |=>
      leader_code == CODE_GRAY12)
    else $error("leader code wrong for 16-bit gray");

  a_pack_count: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_12BIT_PACKED) |=>
      cnt_q == `MPF_N_PACK)
    else $error("packed pair not three bytes");

  a_even_park: assert property (
    @(posedge clk) disable iff (!resetn)
    hold_even |=> even_q == $past(pix_in.data))
    else $error("even pixel not parked");

  a_pack_nibbles: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_12BIT_PACKED && is_odd) |=>
      bytes_q[1] == {$past(pix_in.data[3:0]), $past(even_q[3:0])} &&
      bytes_q[2] == $past(pix_in.data[11:4]) &&
      byte_out.data == $past(even_q[11:4]))
    else $error("packed byte layout wrong");

  a_pack_lone: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_GRAY_12BIT_PACKED && !is_odd) |=>
      cnt_q == `MPF_N_PACK && bytes_q[2] == `MPF_ZERO_BYTE &&
      bytes_q[1][7:4] == `MPF_ZERO_NIB)
    else $error("lone packed pixel not closed with zero");

  a_yuva_chroma: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_YUV422_A) |=>
      byte_out.data == `MPF_ZERO_BYTE && bytes_q[2] == `MPF_ZERO_BYTE &&
      cnt_q == `MPF_N_YUV)
    else $error("yuv422_a chroma not zero");

  a_yuva_luma: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_YUV422_A && is_odd) |=>
      bytes_q[1] == $past(even_q[11:4]) &&
      bytes_q[3] == $past(pix_in.data[11:4]))
    else $error("yuv422_a luma wrong");

  a_yuyv_luma: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_YUV422_YUYV && is_odd) |=>
      byte_out.data == $past(even_q[11:4]) &&
      bytes_q[2] == $past(pix_in.data[11:4]) &&
      bytes_q[3] == `MPF_ZERO_BYTE)
    else $error("yuyv luma order wrong");

  a_yuyv_chroma: assert property (
    @(posedge clk) disable iff (!resetn)
    (load && cur_fmt == MPF_YUV422_YUYV) |=>
      bytes_q[1] == `MPF_ZERO_BYTE && bytes_q[3] == `MPF_ZERO_BYTE &&
      cnt_q == `MPF_N_YUV)
    else $error("yuyv chroma not zero");

  a_pair_even_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    hold_even |=> !byte_valid ##0 pix_ready)
    else $error("even pixel produced bytes alone");

  a_pair_odd_load: assert property (
    @(posedge clk) disable iff (!resetn)
    (pix_take && paired && is_odd) |=> byte_valid && !pix_ready)
    else $error("odd pixel did not release its pair");

endmodule

// file: test/mpf_sink.sv
`timescale 1ns/1ps
module mpf_sink
  import mpf_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire mpf_byte_t byte_out,
  input wire logic byte_valid,
  output logic byte_ready
);
  mpf_byte_t q[$];
  logic ph;
  initial begin
    ph = 1'b0;
    byte_ready = 1'b1;
  end
  // a slow host takes every other cycle so the packer has to hold its bytes
  always @(posedge clk) begin
    if (byte_valid && byte_ready) q.push_back(byte_out);
    ph <= ~ph;
    byte_ready <= #1 ~slow | ph;
  end
endmodule

// file: test/mpf_packer_test.sv
`timescale 1ns/1ps
module mpf_packer_test;
  import mpf_pkg::*;
  logic clk, resetn, pix_valid, slow, pix_ready, byte_valid, byte_ready;
  mpf_fmt_t fmt_sel;
  mpf_pix_t pix_in;
  mpf_byte_t byte_out;
  logic [31:0] leader_code;
  int bad_count, checked;
  logic [11:0] px[$];
  logic [7:0] ex[$];
  mpf_packer mpf_packer_i(.clk(clk), .resetn(resetn), .fmt_sel(fmt_sel),
    .pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .byte_out(byte_out), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .leader_code(leader_code));
  mpf_sink mpf_sink_i(.clk(clk), .slow(slow), .byte_out(byte_out),
    .byte_valid(byte_valid), .byte_ready(byte_ready));
  always #20 clk = ~clk;
  task summarize;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // sends px as one frame in layout f, then judges the captured bytes
  task run(input mpf_fmt_t f, input logic [31:0] code);
    int n, k, w;
    logic [11:0] e, o;
    n = px.size();
    ex.delete();
    mpf_sink_i.q.delete();
    for (k = 0; k < n; k++) begin
      e = px[k];
      o = (k + 1 < n) ? px[k+1] : 12'h000;
      if (f == MPF_GRAY_8BIT) ex.push_back(e[11:4]);
      if (f == MPF_GRAY_16BIT) begin
        ex.push_back(e[7:0]);
        ex.push_back({4'h0, e[11:8]});
      end
      if (k % 2 == 1) continue;
      if (f == MPF_GRAY_12BIT_PACKED) begin
        ex.push_back(e[11:4]);
        ex.push_back({o[3:0], e[3:0]});
        ex.push_back(o[11:4]);
      end
      if (f == MPF_YUV422_A) begin
        ex.push_back(8'h00);
        ex.push_back(e[11:4]);
        ex.push_back(8'h00);
        ex.push_back(o[11:4]);
      end
      if (f == MPF_YUV422_YUYV) begin
        ex.push_back(e[11:4]);
        ex.push_back(8'h00);
        ex.push_back(o[11:4]);
        ex.push_back(8'h00);
      end
    end
    fmt_sel = f;
    for (k = 0; k < n; k++) begin
      pix_in = '{sof: k == 0, eof: k == n - 1, data: px[k]};
      pix_valid = 1'b1;
      w = 0;
      while (!pix_ready && w < 100) begin
        @(posedge clk);
        #1;
        w++;
      end
      @(posedge clk);
      #1;
      // a mid-frame change must not alter the layout
      fmt_sel = (f == MPF_GRAY_8BIT) ? MPF_GRAY_16BIT : MPF_GRAY_8BIT;
    end
    pix_valid = 1'b0;
    repeat (40) @(posedge clk);
    #1;
    cmp("leader", code, leader_code);
    cmp("count", ex.size(), mpf_sink_i.q.size());
    for (k = 0; k < ex.size() && k < mpf_sink_i.q.size(); k++) begin
      cmp("byte", ex[k], mpf_sink_i.q[k].data);
      cmp("sof", k == 0, mpf_sink_i.q[k].sof);
      cmp("eof", k == ex.size() - 1, mpf_sink_i.q[k].eof);
    end
  endtask
  task t_gray8;
    px = '{12'h000, 12'hfff, 12'hab5};
    slow = 1'b0;
    run(MPF_GRAY_8BIT, 32'h1);
  endtask
  task t_gray16;
    px = '{12'hfff, 12'h123, 12'h800};
    slow = 1'b1;
    run(MPF_GRAY_16BIT, 32'h2);
  endtask
  task t_pack;
    px = '{12'h000, 12'hfff, 12'h5a3, 12'hc6e, 12'h9d1};
    slow = 1'b0;
    run(MPF_GRAY_12BIT_PACKED, 32'h3);
  endtask
  task t_yuv;
    px = '{12'hfff, 12'h7c2, 12'h314, 12'h000};
    slow = 1'b1;
    run(MPF_YUV422_A, 32'h4);
    px = '{12'h7c2, 12'hfff, 12'h314};
    slow = 1'b0;
    run(MPF_YUV422_YUYV, 32'h5);
  endtask
  // reset while a 16-bit pixel is still leaving drops it and the leader
  task t_reset;
    slow = 1'b0;
    fmt_sel = MPF_GRAY_16BIT;
    pix_in = '{sof: 1'b1, eof: 1'b0, data: 12'h5a5};
    pix_valid = 1'b1;
    @(posedge clk);
    #1;
    pix_valid = 1'b0;
    cmp("valid_mid", 1'b1, byte_valid);
    cmp("leader_mid", 32'h2, leader_code);
    @(posedge clk);
    #1;
    resetn = 1'b0;
    #1;
    cmp("valid_mid_rst", 1'b0, byte_valid);
    cmp("ready_mid_rst", 1'b1, pix_ready);
    cmp("leader_mid_rst", 32'h1, leader_code);
    @(posedge clk);
    #1;
    resetn = 1'b1;
    // a one-pixel frame carries its start and end flags on the same byte
    px = '{12'h7f0};
    run(MPF_GRAY_8BIT, 32'h1);
  endtask
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    pix_valid = 1'b0;
    slow = 1'b0;
    fmt_sel = MPF_GRAY_8BIT;
    pix_in = '0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    #1;
    cmp("valid_rst", 1'b0, byte_valid);
    resetn = 1'b1;
    t_gray8;
    t_gray16;
    t_pack;
    t_yuv;
    t_reset;
    summarize;
  end
endmodule
